/* rtl/lms_map.svh */
// Constants for the latched mux select controller: register map, fields,
// pin timing. Assumes a 32-bit APB with byte addresses and a 50 ns clock.
`ifndef LMS_MAP_SVH
`define LMS_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LMS_ADDR_W        12
`define LMS_SEL_OFS       12'h000
`define LMS_CMD_OFS       12'h004
`define LMS_STAT_OFS      12'h008

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LMS_SEL_CHAN_LSB  0
`define LMS_SEL_EN_BIT    3
`define LMS_CMD_WRITE_BIT 0
`define LMS_CMD_CLEAR_BIT 1
`define LMS_STAT_BUSY_BIT 0
`define LMS_STAT_EN_BIT   1
`define LMS_STAT_CHAN_LSB 4
`define LMS_STAT_SW_LSB   8

// ----------------------------------------------------------------------
// Reset values and pin timing
// ----------------------------------------------------------------------
`define LMS_SEL_RST       4'h0
`define LMS_CLK_PERIOD_NS 50
`define LMS_T_WR_PULSE_NS 100
`define LMS_T_SETUP_NS    100
`define LMS_T_HOLD_NS     10
`define LMS_T_CLEAR_NS    100

`endif

/* rtl/lms_pkg.sv */
// Types shared by the latched mux select controller.
// Assumes lms_map.svh supplies every number.
package lms_pkg;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    LMS_IDLE   = 5'h01,
    LMS_SETUP  = 5'h02,
    LMS_STROBE = 5'h04,
    LMS_HOLD   = 5'h08,
    LMS_CLEAR  = 5'h10
  } lms_state_type;

  // Pins toward the multiplexer
  typedef struct packed {
    logic master_clear_n;
    logic wr_n;
    logic enable;
    logic chan_sel_bit2;
    logic chan_sel_bit1;
    logic chan_sel_bit0;
  } lms_pins_type;

  // Host copy of what the device latches hold
  typedef struct packed {
    logic       enable;
    logic [2:0] chan;
  } lms_latch_type;

endpackage

/* rtl/lms_ctrl.sv */
// Host-side controller for a latchable 8/4-channel analog multiplexer.
// Assumes an APB master on i_clock and the mux pins wired straight to
// o_pins; the mux has no clock of its own.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
`include "lms_map.svh"
`default_nettype none

// How it works
// [R1] Strobe low: device latches pass inputs through
// [R2] Strobe rise: device keeps last inputs
// [R3] Clear low empties all device latches
// [R4] No load during clear or enable low
// [R5] Enable gates address load, latched itself
// [R6] Latched code plus enable closes one switch
// [R7] Latched enable zero opens every switch
// [R8] Clear held at power-up; off until write
// [R9] Strobe formed from select and write; data settles
// [R10] Cascaded devices: enable off unselected ones
// [R11] Enable may be tied high or decoded
// [R12] Single-ended: code n closes switch n+1
// [R13] Differential: two bits, pair n+1
// [R14] Cleared latches mean enable zero, all off
module lms_ctrl
  import lms_pkg::*;
#(
  parameter bit P_DIFF = 1'b0  // 1: four-pair variant, two select bits
) (
  // Clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_rst_n,
  // APB slave
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [`LMS_ADDR_W-1:0]   i_paddr,
  input  wire logic [31:0]              i_pwdata,
  output logic      [31:0]              o_prdata,
  output logic                          o_pready,
  output logic                          o_pslverr,
  // Multiplexer pins
  output lms_pins_type                  o_pins
);

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  localparam int CLK_NS = `LMS_CLK_PERIOD_NS;

  // Least times round up, never below one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction

  localparam int WR_NS  = (`LMS_T_WR_PULSE_NS > `LMS_T_SETUP_NS) ?
                          `LMS_T_WR_PULSE_NS : `LMS_T_SETUP_NS;
  localparam int WR_CYC = cyc_min(WR_NS);
  localparam int HD_CYC = cyc_min(`LMS_T_HOLD_NS);
  localparam int RS_CYC = cyc_min(`LMS_T_CLEAR_NS);
  localparam int CNT_W  = 4;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  lms_state_type      state_q;
  logic [CNT_W-1:0]   cnt_q;
  lms_pins_type       pins_q;
  lms_latch_type      sel_q;
  lms_latch_type      shadow_q;
  logic [7:0]         sw_on;
  logic               pready_q;
  logic [31:0]        prdata_q;
  logic               pslverr_q;
  logic               acc_done;
  logic               wr_acc;
  logic               map_hit;
  logic               go_write;
  logic               go_clear;
  logic               busy;
  logic [31:0]        rd_word;
  logic [2:0]         chan_drv;

  // ----------------------------------------------------------------------
  // APB access decode
  // ----------------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  assign acc_done = i_psel & i_penable & pready_q;
  assign wr_acc   = acc_done & i_pwrite;
  assign map_hit  = (i_paddr == `LMS_SEL_OFS) || (i_paddr == `LMS_CMD_OFS) ||
                    (i_paddr == `LMS_STAT_OFS);
  assign busy     = (state_q != LMS_IDLE);
  // Commands while busy are dropped; poll the busy bit first
  assign go_clear = wr_acc & (i_paddr == `LMS_CMD_OFS) & ~busy &
                    i_pwdata[`LMS_CMD_CLEAR_BIT];
  assign go_write = wr_acc & (i_paddr == `LMS_CMD_OFS) & ~busy &
                    i_pwdata[`LMS_CMD_WRITE_BIT] & ~i_pwdata[`LMS_CMD_CLEAR_BIT];
  // Differential variant never uses the top select bit
  assign chan_drv = P_DIFF ? {1'b0, sel_q.chan[1:0]} : sel_q.chan;

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    case (i_paddr)
      `LMS_SEL_OFS: begin
        rd_word[`LMS_SEL_CHAN_LSB +: 3] = sel_q.chan;
        rd_word[`LMS_SEL_EN_BIT]        = sel_q.enable;
      end
      `LMS_STAT_OFS: begin
        rd_word[`LMS_STAT_BUSY_BIT]      = busy;
        rd_word[`LMS_STAT_EN_BIT]        = shadow_q.enable;
        rd_word[`LMS_STAT_CHAN_LSB +: 3] = shadow_q.chan;
        rd_word[`LMS_STAT_SW_LSB +: 8]   = sw_on;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Handshake and read data, all registered
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= i_psel & i_penable & ~pready_q;
      if (i_psel & i_penable & ~pready_q) begin
        prdata_q  <= i_pwrite ? 32'h0000_0000 : rd_word;
        pslverr_q <= ~map_hit;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Selection register steers the next write
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q <= `LMS_SEL_RST;
    end else if (wr_acc && (i_paddr == `LMS_SEL_OFS)) begin
      sel_q.chan   <= i_pwdata[`LMS_SEL_CHAN_LSB +: 3];
      sel_q.enable <= i_pwdata[`LMS_SEL_EN_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Pin sequencer
  // ----------------------------------------------------------------------
  // Reset parks in the clear state so the mux stays off at power-up
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= LMS_CLEAR;
      cnt_q   <= '0;
      pins_q  <= '{master_clear_n: 1'b0, wr_n: 1'b1, default: 1'b0};  // R8
    end else begin
      case (state_q)
        LMS_IDLE: begin
          cnt_q <= '0;
          if (go_clear) begin
            state_q               <= LMS_CLEAR;
            pins_q.master_clear_n <= 1'b0;  // R3
          end else if (go_write) begin
            state_q              <= LMS_SETUP;
            pins_q.enable        <= sel_q.enable;  // R11
            pins_q.chan_sel_bit2 <= chan_drv[2];
            pins_q.chan_sel_bit1 <= chan_drv[1];
            pins_q.chan_sel_bit0 <= chan_drv[0];
          end
        end
        LMS_SETUP: begin
          // Data settles one cycle before the strobe falls
          state_q     <= LMS_STROBE;
          pins_q.wr_n <= 1'b0;  // R9
        end
        LMS_STROBE: begin
          // Low long enough for both pulse width and data setup
          if (cnt_q == CNT_W'(WR_CYC - 1)) begin
            state_q     <= LMS_HOLD;
            cnt_q       <= '0;
            pins_q.wr_n <= 1'b1;  // R2
          end else begin
            cnt_q <= cnt_q + 1'b1;  // R1
          end
        end
        LMS_HOLD: begin
          // Data kept past the rising strobe edge
          if (cnt_q == CNT_W'(HD_CYC - 1)) begin
            state_q <= LMS_IDLE;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        LMS_CLEAR: begin
          if (cnt_q == CNT_W'(RS_CYC - 1)) begin
            state_q               <= LMS_IDLE;
            cnt_q                 <= '0;
            pins_q.master_clear_n <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= LMS_IDLE;
          cnt_q   <= '0;
          pins_q  <= '{master_clear_n: 1'b1, wr_n: 1'b1, default: 1'b0};
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Copy of the device latches
  // ----------------------------------------------------------------------
  // Tracks what the mux holds after each strobe, so software can see it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shadow_q <= '0;  // R14
    end else if (state_q == LMS_CLEAR) begin
      shadow_q <= '0;  // R3
    end else if ((state_q == LMS_STROBE) && (cnt_q == CNT_W'(WR_CYC - 1))) begin
      shadow_q.enable <= pins_q.enable;  // R5
      if (pins_q.enable) begin
        shadow_q.chan <= {pins_q.chan_sel_bit2, pins_q.chan_sel_bit1,
                          pins_q.chan_sel_bit0};  // R4
      end
    end
  end

  // Switch decode of the copy, one bit per switch
  for (genvar gi = 0; gi < 8; gi++) begin : g_sw
    if (P_DIFF && (gi >= 4)) begin : g_none
      assign sw_on[gi] = 1'b0;  // R13
    end else begin : g_dec
      assign sw_on[gi] = shadow_q.enable && (shadow_q.chan == 3'(gi));  // R6 R7 R12
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_pins    = pins_q;  // R10

endmodule

`default_nettype wire

/* tb/lms_mux_model.sv */
// Behavioural model of the multiplexer's latch and decode path.
// Assumes it sees the controller's pins directly; it has no clock.
`timescale 1ns/1ns
`default_nettype none
module lms_mux_model
  import lms_pkg::*;
#(
  parameter bit P_DIFF = 1'b0  // Four-pair variant, two select bits
) (
  // Pins from the controller
  input  wire lms_pins_type i_pins,
  // Closed switch, switch n+1 on bit n
  output logic [7:0]        o_sw
);
  logic       en_q;
  logic [2:0] chan_q;
  // Clear wins; latches are open while the strobe is low
  always_latch begin
    if (!i_pins.master_clear_n) begin
      en_q   <= 1'b0;
      chan_q <= 3'h0;
    end else if (!i_pins.wr_n) begin
      en_q <= i_pins.enable;
      if (i_pins.enable)
        chan_q <= {i_pins.chan_sel_bit2 & !P_DIFF, i_pins.chan_sel_bit1, i_pins.chan_sel_bit0};
    end
  end
  // Enable low opens every switch
  assign o_sw = en_q ? (8'h01 << chan_q) : 8'h00;
endmodule
`default_nettype wire

/* tb/lms_ctrl_props.sv */
// Checker on the controller's ports.
// Assumes it is bound onto lms_ctrl.
`timescale 1ns/1ns
`include "lms_map.svh"
`default_nettype none
module lms_ctrl_props
  import lms_pkg::*;
(
  // Clock, reset and bus
  input wire logic                   i_clock,
  input wire logic                   i_rst_n,
  input wire logic                   i_psel,
  input wire logic                   i_penable,
  input wire logic                   i_pwrite,
  input wire logic [`LMS_ADDR_W-1:0] i_paddr,
  input wire logic [31:0]            i_pwdata,
  input wire logic [31:0]            o_prdata,
  input wire logic                   o_pready,
  input wire logic                   o_pslverr,
  // Pins
  input wire lms_pins_type           o_pins
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ------------------------------------------------------------------
  // Pin and bus timing
  // ------------------------------------------------------------------
  a_reset_clear: assert property (
    $rose(i_rst_n) |-> !o_pins.master_clear_n ##1 !o_pins.master_clear_n)
    else $error("clear too short after reset");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_one_wait: assert property (i_psel && $rose(i_penable) |-> !o_pready ##1 o_pready)
    else $error("bus wait not one cycle");
  a_strobe_width: assert property (
    $fell(o_pins.wr_n) |-> ##1 !o_pins.wr_n ##1 o_pins.wr_n)
    else $error("strobe width wrong");
  a_data_steady: assert property (
    (!o_pins.wr_n || $rose(o_pins.wr_n)) |-> $stable(o_pins[3:0]))
    else $error("select moved around strobe");
  a_clear_width: assert property (
    $fell(o_pins.master_clear_n) |-> ##1 !o_pins.master_clear_n ##1 o_pins.master_clear_n)
    else $error("clear width wrong");
  a_no_strobe_clear: assert property (
    !o_pins.master_clear_n |-> o_pins.wr_n)
    else $error("strobe during clear");
  a_bus_error: assert property (o_pready |->
    o_pslverr == !(i_paddr inside {`LMS_SEL_OFS, `LMS_CMD_OFS, `LMS_STAT_OFS}))
    else $error("error flag wrong");
endmodule
bind lms_ctrl lms_ctrl_props u_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_pins(o_pins));
`default_nettype wire

/* tb/test_latched_mux_select.sv */
// Self-checking bench for the mux select controller.
// Assumes the mux model on the pins and APB for all orders.
`timescale 1ns/1ns
`include "lms_map.svh"
`default_nettype none
module test_latched_mux_select
  import lms_pkg::*;
;
  logic         clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  lms_pins_type pins;
  logic [7:0]   sw;
  int           bad_count = 0, check_count = 0, cycles = 0;
  logic         pready_d, pslverr_d;
  logic [31:0]  prdata_d, rd_d;
  lms_pins_type pins_d;
  logic [7:0]   sw_d;
  lms_ctrl #(.P_DIFF(1'b0)) uut (.i_clock(clock), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_pins(pins));
  lms_mux_model u_mux (.i_pins(pins), .o_sw(sw));
  // Four-pair variant on the same bus, so the two-bit decode is exercised too
  lms_ctrl #(.P_DIFF(1'b1)) uut_diff (.i_clock(clock), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata_d), .o_pready(pready_d), .o_pslverr(pslverr_d), .o_pins(pins_d));
  lms_mux_model #(.P_DIFF(1'b1)) u_mux_diff (.i_pins(pins_d), .o_sw(sw_d));
  // ------------------------------------------------------------------
  // Clock, hang guard, helpers
  // ------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Cuts a hang short well beyond the few hundred cycles needed
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      test_done;
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One transfer; waits for ready, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    rd_d = prdata_d;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin apb(1'b0, `LMS_STAT_OFS, 32'h0); n++; end while (rd[0] !== 1'b0 && n < 20);
    chk(rd[0], 32'h0);
  endtask
  function automatic logic [31:0] st(input logic [2:0] c, input logic en);
    return {16'h0, en ? 8'h01 << c : 8'h00, 1'h0, c, 2'h0, en, 1'h0};
  endfunction
  // Select and strobe; switches must follow while the strobe is low
  task automatic load(input logic [2:0] c, input logic en);
    int n;
    apb(1'b1, `LMS_SEL_OFS, {28'h0, en, c});
    apb(1'b1, `LMS_CMD_OFS, 32'h1);
    n = 0;
    while (pins.wr_n !== 1'b0 && n < 10) begin @(negedge clock); n++; end
    chk(pins.wr_n, 32'h0);
    chk(sw, en ? 8'h01 << c : 8'h00);
    wait_idle;
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    wait_idle;
    chk(rd, 32'h0);
    chk(sw, 32'h0);
    chk(sw_d, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_chans;
    for (int c = 0; c < 8; c++) begin
      load(c[2:0], 1'b1);
      chk(rd, st(c[2:0], 1'b1));
      chk(sw, 8'h01 << c);
      chk(sw_d, 8'h01 << c[1:0]);
      chk(rd_d, {16'h0, 8'h01 << c[1:0], 2'h0, c[1:0], 2'h0, 1'b1, 1'b0});
    end
    $display("test channels done");
  endtask
  task automatic t_disable;
    load(3'h5, 1'b0);
    chk(sw, 32'h0);
    chk(rd, st(3'h7, 1'b0));
    load(3'h2, 1'b1);
    chk(sw, 32'h4);
    $display("test enable done");
  endtask
  task automatic t_clear;
    apb(1'b1, `LMS_SEL_OFS, 32'hE);
    apb(1'b1, `LMS_CMD_OFS, 32'h1);
    apb(1'b1, `LMS_CMD_OFS, 32'h2);  // Busy, so ignored
    wait_idle;
    chk(sw, 32'h40);
    apb(1'b1, `LMS_CMD_OFS, 32'h3);  // Clear wins over strobe
    wait_idle;
    chk(sw, 32'h0);
    chk(rd, 32'h0);
    $display("test clear done");
  endtask
  task automatic t_unmapped;
    apb(1'b0, 12'h00C, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, `LMS_CMD_OFS, 32'h0);
    chk(err, 32'h0);
    chk(rd, 32'h0);
    // Selection register still holds the last value written in the clear test
    apb(1'b0, `LMS_SEL_OFS, 32'h0);
    chk(err, 32'h0);
    chk(rd, 32'hE);
    $display("test bus done");
  endtask
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_chans;
    t_disable;
    t_clear;
    t_unmapped;
    test_done;
  end
endmodule
`default_nettype wire
